// [hdl/scs_map.svh]
// slow clock source select: offsets-free constant map (resets, codes)
// assumes inclusion by bare name from the package or design file
// Notes on behaviour
// RL1 - no crystal: run everything from rc clock
// RL2 - crystal present and running: use crystal clock
// RL3 - hold output phase stable during source change
// RL4 - crystal lost: revert to rc oscillator
// RL5 - sense bit: 0 rc, 1 crystal
// RL6 - flag set on every source change
// RL7 - interrupt only while change mask is clear
// RL8 - startup sequencer enables output drivers
// RL9 - power fsm and enable bit gate host clock
// RL10 - host enable resets to 1 on backup por
// RL11 - peripheral clock only in normal on mode
// RL12 - keep bit holds host clock in all states
// RL13 - keep bit clear: host clock off when off
// RL14 - drive field default 00, code 10 high-z
// RL15 - backup por resets clock configuration bits
// RL16 - flag latched; set wins over clear
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH
`define SCS_HOST_EN_RST 1'b1
`define SCS_KEEP_RST 1'b0
`define SCS_MASK_RST 1'b1
`define SCS_DRV_RST 2'h0
`define SCS_DRV_HIZ 2'h2
`define SCS_SENSE_RC 1'b0
`define SCS_SENSE_XTAL 1'b1
`endif

// [hdl/scs_pkg.sv]
// slow clock source select: shared types
// assumes the map header supplies the constant values
package scs_pkg;
  typedef enum logic [1:0] {SCS_PWR_OFF, SCS_PWR_LOWPOWER, SCS_PWR_ON} scs_pwr_t;
  typedef struct packed {
    logic host_en;
    logic keep_on;
    logic change_mask;
    logic [1:0] drive;
  } scs_cfg_t;
endpackage

// [hdl/scs_clock_select.sv]
// slow clock source select: picks rc or crystal slow clock, glitch-free, gates output buffers
// assumes slow clocks and crystal-good arrive as asynchronous pins, sampled at clk_sys
`timescale 1ns/10ps
`include "scs_map.svh"
module scs_clock_select (
  // system
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic backup_domain_por_n,
  // oscillators
  input wire logic rc_clock_in,
  input wire logic xtal_clock_in,
  input wire logic xtal_running,
  // power state machine
  input wire logic startup_done,
  input wire scs_pkg::scs_pwr_t pwr_state,
  input wire logic lowpower_host_clock_prog,
  // configuration writes
  input wire logic cfg_write,
  input wire scs_pkg::scs_cfg_t cfg_wdata,
  input wire logic clock_source_change_clear,
  // status
  output logic clock_source_sense,
  output logic clock_source_change_flag,
  output logic clock_source_change_irq,
  output scs_pkg::scs_cfg_t cfg_rdata,
  // clock outputs
  output logic slow_clock_to_host,
  output logic slow_clock_to_host_oe,
  output logic slow_clock_to_peripherals,
  output logic slow_clock_to_peripherals_oe,
  output logic [1:0] peripheral_drive_level
);

  ////////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers: both slow clocks and crystal-good are asynchronous pins
  logic [1:0] rc_sync_reg;
  logic [1:0] xt_sync_reg;
  logic [1:0] good_sync_reg;
  logic sel_reg, sel_next, out_reg, out_next;
  logic switching_reg, switching_next;
  logic sense_d_reg;
  logic flag_reg, flag_next;
  scs_pkg::scs_cfg_t cfg_reg, cfg_next;
  logic en_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) rc_sync_reg <= 2'h0;
    else rc_sync_reg <= {rc_sync_reg[0], rc_clock_in};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) xt_sync_reg <= 2'h0;
    else xt_sync_reg <= {xt_sync_reg[0], xtal_clock_in};
  end

  // crystal-good restarts low after reset, so the rc clock is always the first source
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) good_sync_reg <= 2'h0;
    else good_sync_reg <= {good_sync_reg[0], xtal_running};
  end

  wire rc_s = rc_sync_reg[1];
  wire xt_s = xt_sync_reg[1];
  wire want_xtal = good_sync_reg[1]; // RL2 RL4
  // one source mux, so the old and the new clock pick cannot drift apart
  function automatic logic pick_clk(input logic use_xtal, input logic xt, input logic rc);
    pick_clk = use_xtal ? xt : rc;
  endfunction

  wire cur_clk = pick_clk(sel_reg, xt_s, rc_s);
  wire new_clk = pick_clk(want_xtal, xt_s, rc_s);

  ////////////////////////////////////////////////////////////////////////////////
  // switch only when both old and new clocks sit low, output held low meanwhile
  // a free-running output during the change could show a runt pulse
  wire switch_point = switching_reg && !cur_clk && !new_clk; // RL3
  wire need_switch = want_xtal != sel_reg;
  assign switching_next = need_switch && !switch_point;
  assign sel_next = switch_point ? want_xtal : sel_reg; // RL2 RL4
  assign out_next = (switching_reg || switching_next) ? (out_reg & cur_clk) : cur_clk; // RL1 RL3

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `SCS_SENSE_RC;
      switching_reg <= 1'b0;
      out_reg <= 1'b0;
      sense_d_reg <= `SCS_SENSE_RC;
    end else begin
      sel_reg <= sel_next;
      switching_reg <= switching_next;
      out_reg <= out_next;
      sense_d_reg <= sel_reg;
    end
  end

  assign clock_source_sense = sel_reg; // RL5
  wire src_changed = sel_reg != sense_d_reg;
  assign flag_next = src_changed | (flag_reg & !clock_source_change_clear); // RL6 RL16

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) flag_reg <= 1'b0;
    else flag_reg <= flag_next;
  end

  assign clock_source_change_flag = flag_reg;
  assign clock_source_change_irq = flag_reg & !cfg_reg.change_mask; // RL7

  ////////////////////////////////////////////////////////////////////////////////
  // configuration lives in the backup domain: only its por resets it
  assign cfg_next = cfg_write ? cfg_wdata : cfg_reg;

  always_ff @(posedge clk_sys or negedge backup_domain_por_n) begin
    if (!backup_domain_por_n) begin
      cfg_reg <= '{`SCS_HOST_EN_RST, `SCS_KEEP_RST, `SCS_MASK_RST, `SCS_DRV_RST}; // RL10 RL15
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  assign cfg_rdata = cfg_reg;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) en_reg <= 1'b0;
    else en_reg <= en_reg | startup_done; // RL8
  end

  wire pwr_on = pwr_state == scs_pkg::SCS_PWR_ON;
  wire pwr_lp = pwr_state == scs_pkg::SCS_PWR_LOWPOWER;
  // off never appears here, so a cleared keep bit drops the host clock in off
  wire host_by_state = pwr_on || (pwr_lp && lowpower_host_clock_prog); // RL9 RL13
  wire host_by_sw = cfg_reg.host_en && host_by_state; // RL9
  // keep bit overrides both the state machine and the enable bit
  wire host_on = en_reg && (cfg_reg.keep_on || host_by_sw); // RL12
  wire peri_hiz = cfg_reg.drive == `SCS_DRV_HIZ; // RL14
  // limitation: high impedance is shown only as a dropped output enable
  wire peri_on = en_reg && pwr_on && !peri_hiz; // RL11

  assign slow_clock_to_host = out_reg & host_on;
  assign slow_clock_to_host_oe = host_on;
  assign slow_clock_to_peripherals = out_reg & peri_on;
  assign slow_clock_to_peripherals_oe = peri_on;
  assign peripheral_drive_level = cfg_reg.drive; // RL14

  ////////////////////////////////////////////////////////////////////////////////
  // change flag and interrupt
  flag_set_a: assert property ( // RL6
    @(posedge clk_sys) disable iff (!rst_n) src_changed |=> clock_source_change_flag)
    else $error("change flag missed");
  flag_hold_a: assert property ( // RL16
    @(posedge clk_sys) disable iff (!rst_n) flag_reg && !clock_source_change_clear |=> flag_reg)
    else $error("flag dropped");
  flag_clear_a: assert property ( // RL16
    @(posedge clk_sys) disable iff (!rst_n)
    flag_reg && clock_source_change_clear && !src_changed |=> !flag_reg) else $error("no clear");
  irq_mask_a: assert property ( // RL7
    @(posedge clk_sys) disable iff (!rst_n) clock_source_change_irq |-> !cfg_reg.change_mask)
    else $error("masked irq");
  irq_raise_a: assert property ( // RL7
    @(posedge clk_sys) disable iff (!rst_n) flag_reg && !cfg_reg.change_mask |-> clock_source_change_irq)
    else $error("unmasked irq missing");

  // source switching
  glitch_low_a: assert property ( // RL3
    @(posedge clk_sys) disable iff (!rst_n) switching_reg && !out_reg |=> !out_reg)
    else $error("runt during switch");
  switch_low_a: assert property ( // RL3
    @(posedge clk_sys) disable iff (!rst_n) $changed(sel_reg) |-> !out_reg)
    else $error("switch while output high");
  follow_xtal_a: assert property ( // RL2
    @(posedge clk_sys) disable iff (!rst_n) !sel_reg && want_xtal |-> ##[1:400] sel_reg)
    else $error("no switch to crystal");
  revert_a: assert property ( // RL4
    @(posedge clk_sys) disable iff (!rst_n) sel_reg && !want_xtal |-> ##[1:400] !sel_reg)
    else $error("no revert");

  // output gating
  startup_gate_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!rst_n)
    !en_reg |-> !slow_clock_to_host_oe && !slow_clock_to_peripherals_oe) else $error("early oe");
  en_sticky_a: assert property ( // RL8
    @(posedge clk_sys) disable iff (!rst_n) en_reg |=> en_reg)
    else $error("driver enable lost");
  host_direct_a: assert property ( // RL9
    @(posedge clk_sys) disable iff (!rst_n)
    !cfg_reg.keep_on && !cfg_reg.host_en |-> !slow_clock_to_host_oe) else $error("host not off");
  lp_host_a: assert property ( // RL9
    @(posedge clk_sys) disable iff (!rst_n)
    en_reg && host_by_sw && pwr_lp |-> slow_clock_to_host_oe) else $error("lowpower host off");
  host_gate_a: assert property ( // RL9
    @(posedge clk_sys) disable iff (!rst_n) !slow_clock_to_host_oe |-> !slow_clock_to_host)
    else $error("host clock leaks");
  peri_on_a: assert property ( // RL11
    @(posedge clk_sys) disable iff (!rst_n) slow_clock_to_peripherals_oe |-> pwr_on)
    else $error("peri clock outside on");
  peri_gate_a: assert property ( // RL11
    @(posedge clk_sys) disable iff (!rst_n)
    !slow_clock_to_peripherals_oe |-> !slow_clock_to_peripherals) else $error("peri clock leaks");
  keep_host_a: assert property ( // RL12
    @(posedge clk_sys) disable iff (!rst_n) en_reg && cfg_reg.keep_on |-> slow_clock_to_host_oe)
    else $error("host clock off");
  off_host_a: assert property ( // RL13
    @(posedge clk_sys) disable iff (!rst_n)
    pwr_state == scs_pkg::SCS_PWR_OFF && !cfg_reg.keep_on |-> !slow_clock_to_host_oe)
    else $error("host clock in off");
  hiz_drv_a: assert property ( // RL14
    @(posedge clk_sys) disable iff (!rst_n) peri_hiz |-> !slow_clock_to_peripherals_oe)
    else $error("hiz");
  cfg_load_a: assert property ( // RL10
    @(posedge clk_sys) disable iff (!backup_domain_por_n) cfg_write |=> cfg_rdata == $past(cfg_wdata))
    else $error("config write lost");

  cov_to_xtal: cover property (@(posedge clk_sys) disable iff (!rst_n) !sel_reg ##1 sel_reg);
  cov_to_rc: cover property (@(posedge clk_sys) disable iff (!rst_n) sel_reg ##1 !sel_reg);
  cov_irq: cover property (@(posedge clk_sys) disable iff (!rst_n) clock_source_change_irq);
  cov_race: cover property (@(posedge clk_sys) disable iff (!rst_n)
    src_changed && clock_source_change_clear);
  cov_hiz: cover property (@(posedge clk_sys) disable iff (!rst_n) pwr_on && en_reg && peri_hiz);
endmodule

// [verification/scs_osc_model.sv]
// rc and crystal oscillators seen by the selector, scaled fast
// assumes the bench starts and stops the crystal; a stopped one stands low
`timescale 1ns/10ps
module scs_osc_model (
  // command
  input wire logic xtal_on,
  // oscillators
  output logic rc_clock_in,
  output logic xtal_clock_in,
  output logic xtal_running
);
  initial rc_clock_in = 1'b0;
  always #150 rc_clock_in = ~rc_clock_in;
  initial xtal_clock_in = 1'b0;
  always #155 xtal_clock_in = xtal_on & ~xtal_clock_in;
  assign xtal_running = xtal_on;
endmodule

// [verification/slow_clock_source_select_tb.sv]
// scenario bench for the slow clock source selector
// assumes bench-driven inputs change at falling clk_sys edges; the crystal clock also toggles on rising ones
`timescale 1ns/10ps
module slow_clock_source_select_tb;
  logic clk_sys = 1'b0, rst_n = 1'b0, por_n = 1'b0, xtal_on = 1'b0;
  logic rc, xt, xrun, start = 1'b0, lp_prog = 1'b0, cfg_write = 1'b0, clr = 1'b0;
  logic sense, flag, irq, h, h_oe, p, p_oe;
  logic [1:0] drv;
  scs_pkg::scs_pwr_t pwr = scs_pkg::SCS_PWR_OFF;
  scs_pkg::scs_cfg_t wd = '0, rd;
  int n_fail = 0, cmp_count = 0;
  always #5 clk_sys = ~clk_sys;
  scs_osc_model u_scs_osc_model (.xtal_on(xtal_on), .rc_clock_in(rc), .xtal_clock_in(xt),
    .xtal_running(xrun));
  scs_clock_select u_scs_clock_select (.clk_sys(clk_sys), .rst_n(rst_n),
    .backup_domain_por_n(por_n), .rc_clock_in(rc), .xtal_clock_in(xt), .xtal_running(xrun),
    .startup_done(start), .pwr_state(pwr), .lowpower_host_clock_prog(lp_prog),
    .cfg_write(cfg_write), .cfg_wdata(wd), .clock_source_change_clear(clr),
    .clock_source_sense(sense), .clock_source_change_flag(flag),
    .clock_source_change_irq(irq), .cfg_rdata(rd), .slow_clock_to_host(h),
    .slow_clock_to_host_oe(h_oe), .slow_clock_to_peripherals(p),
    .slow_clock_to_peripherals_oe(p_oe), .peripheral_drive_level(drv));
  task automatic give_verdict();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one-cycle write, then a cycle for the register to show
  task automatic wr(input logic [4:0] c);
    @(negedge clk_sys) cfg_write = 1'b1;
    wd = c;
    @(negedge clk_sys) cfg_write = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic count_edges(input int n, output int nh, output int np);
    logic lh, lp;
    nh = 0;
    np = 0;
    lh = h;
    lp = p;
    repeat (n) begin
      @(negedge clk_sys);
      if (h !== lh) nh++;
      if (p !== lp) np++;
      lh = h;
      lp = p;
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task automatic wait_sense(input logic v);
    int i;
    for (i = 0; i < 400 && sense !== v; i++) @(negedge clk_sys);
    if (i == 400) begin
      n_fail++;
      give_verdict();
    end
  endtask
  task automatic t_xtal();
    chk(rd, 5'h14);
    chk(sense, 1'b0);
    xtal_on = 1'b1;
    wait_sense(1'b1);
    tick(2);
    chk(flag, 1'b1);
    chk(irq, 1'b0);
    wr(5'h10);
    chk(irq, 1'b1);
    clr = 1'b1;
    tick(1);
    clr = 1'b0;
    tick(1);
    chk({flag, irq}, 2'h0);
    xtal_on = 1'b0;
    wait_sense(1'b0);
    tick(2);
    chk({flag, irq}, 2'h3);
    $display("done source switching");
  endtask
  task automatic t_power();
    int nh, np;
    pwr = scs_pkg::SCS_PWR_ON;
    tick(3);
    chk({p_oe, h_oe}, 2'h0);
    start = 1'b1;
    tick(3);
    chk({p_oe, h_oe}, 2'h3);
    count_edges(200, nh, np);
    chk(nh != 0, 1'b1);
    chk(np != 0, 1'b1);
    wr(5'h00);
    chk({p_oe, h_oe}, 2'h2);
    wr(5'h12);
    chk({p_oe, drv}, 3'h2);
    count_edges(100, nh, np);
    chk(np != 0, 1'b0);
    pwr = scs_pkg::SCS_PWR_LOWPOWER;
    wr(5'h10);
    chk(p_oe, 1'b0);
    chk(h_oe, 1'b0);
    lp_prog = 1'b1;
    tick(1);
    chk(h_oe, 1'b1);
    lp_prog = 1'b0;
    tick(1);
    chk(h_oe, 1'b0);
    pwr = scs_pkg::SCS_PWR_OFF;
    tick(2);
    chk(h_oe, 1'b0);
    wr(5'h18);
    chk(h_oe, 1'b1);
    por_n = 1'b0;
    tick(1);
    por_n = 1'b1;
    tick(1);
    chk(rd, 5'h14);
    $display("done output gating");
  endtask
  task automatic t_reset();
    xtal_on = 1'b1;
    wait_sense(1'b1);
    rst_n = 1'b0;
    tick(1);
    chk({sense, flag, h_oe, p_oe}, 4'h0);
    rst_n = 1'b1;
    tick(2);
    chk(sense, 1'b0);
    wait_sense(1'b1);
    tick(2);
    chk(flag, 1'b1);
    xtal_on = 1'b0;
    wait_sense(1'b0);
    $display("done mid-run reset");
  endtask
  initial begin
    tick(10);
    rst_n = 1'b1;
    por_n = 1'b1;
    tick(2);
    t_xtal();
    t_power();
    t_reset();
    give_verdict();
  end
endmodule
